// [src/rcoe_pkg.sv]
// Constants, carriers and helpers for the receive checksum engine
package rcoe_pkg;

    // Register port offsets (byte addresses)
    localparam int              RCOE_ADDR_W        = 4;
    localparam logic [3:0]      RCOE_OFF_CTRL      = 4'h0;
    localparam logic [3:0]      RCOE_OFF_VLAN      = 4'h4;
    localparam logic [3:0]      RCOE_OFF_STAT      = 4'h8;

    // Control register field positions
    localparam int              RCOE_CTRL_EN_BIT   = 0;
    localparam int              RCOE_CTRL_MODE_BIT = 1;

    // Values after reset
    localparam logic            RCOE_EN_RST        = 1'b0;
    localparam logic            RCOE_MODE_RST      = 1'b0;
    localparam logic [15:0]     RCOE_VLAN_RST      = 16'h8100;

    // Frame layout
    localparam int              RCOE_POS_W         = 12;
    localparam logic [11:0]     RCOE_TYPE_POS      = 12'h00c;
    localparam logic [11:0]     RCOE_HDR_BYTES     = 12'h00e;
    localparam logic [11:0]     RCOE_SNAP_BYTES    = 12'h008;
    localparam logic [11:0]     RCOE_VLAN_BYTES    = 12'h004;
    localparam logic [1:0]      RCOE_MAX_VLAN      = 2'h2;
    localparam logic [15:0]     RCOE_LEN_TYPE_MIN  = 16'h0600;

    // Receive status word length field
    localparam int              RCOE_STAT_LEN_LSB  = 16;
    localparam int              RCOE_STAT_LEN_W    = 14;
    localparam logic [13:0]     RCOE_CSUM_BYTES    = 14'h0002;

    // Frame byte as carried on the receive path
    typedef struct packed {
        logic [7:0] data;
        logic       fcs;
        logic       last;
    } rcoe_byte_t;

    // Stream states
    typedef enum logic [1:0] {
        RCOE_IDLE,
        RCOE_FRAME,
        RCOE_APP_LO,
        RCOE_APP_HI
    } rcoe_st_t;

    // Complete state of the engine
    typedef struct packed {
        rcoe_st_t                st;
        logic                    ctrl_en;
        logic                    ctrl_mode;
        logic [15:0]             vlan_type;
        logic                    en;
        logic                    mode;
        logic [RCOE_POS_W-1:0]   pos;
        logic [RCOE_POS_W-1:0]   type_pos;
        logic [RCOE_POS_W-1:0]   start_pos;
        logic                    start_ok;
        logic [1:0]              vlan_cnt;
        logic [7:0]              type_hi;
        logic                    odd;
        logic [7:0]              low;
        logic [15:0]             sum;
        logic                    stat_pend;
        logic [31:0]             stat;
        rcoe_byte_t              o_byte;
        logic                    o_valid;
        logic                    o_sval;
        logic [31:0]             o_stat;
        logic [31:0]             rdata;
    } rcoe_state_t;

    // 16-bit add with end-around carry
    function automatic logic [15:0] rcoe_fold(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[15:0] + {15'h0000, s[16]};
    endfunction : rcoe_fold

endpackage : rcoe_pkg

// [src/rcoe_engine.sv]
// Receive checksum engine between the MAC receive path and the RX data FIFO
//
// Contract
// R1 - When enabled, a 16-bit checksum is built over each frame as it streams.
// R2 - Mode 0 sums every byte after the first 14, stopping before the FCS.
// R3 - Mode 1 parses Type II, SNAP and VLAN frames, summing from layer-3 start.
// R4 - A VLAN tag is seen when the type matches the programmable tag type.
// R5 - At most two tags skipped; a third tag's identifier is the type field.
// R6 - Checksum bytes follow the last frame byte, ahead of the status word.
// R7 - Status length field grows by two when a checksum is appended.
// R8 - While enabled, every frame gets a checksum regardless of its type.
// R9 - One control bit enables the engine, another selects mode 0 or 1.
// R10 - When disabled, data and status pass through untouched.
// R11 - Software stops and flushes the receiver before changing enable or mode.
// R12 - Software never enables pad stripping while the engine is enabled.
// R13 - Sum taken a 16-bit word at a time; odd count padded with zero.
// R14 - Later byte of each pair is the high byte, earlier the low byte.
// R15 - Carry out of every addition is folded back into the sum.
// R16 - Odd frame: last word holds final byte low, zero high.
// R17 - Reset gives disabled, mode 0; settings taken only at frame start.
//
// Our own choices: the plain strobed port and the placing of the registers.
module rcoe_engine
    import rcoe_pkg::*;
(
    // Clock and reset
    input  wire logic                   CLK_I,
    input  wire logic                   NRST_I,
    // Register port
    input  wire logic [RCOE_ADDR_W-1:0] REG_ADDR_I,
    input  wire logic [31:0]            REG_WDATA_I,
    input  wire logic                   REG_WE_I,
    input  wire logic                   REG_RE_I,
    output logic      [31:0]            REG_RDATA_O,
    // Receive stream from the MAC
    input  wire rcoe_byte_t             RX_BYTE_I,
    input  wire logic                   RX_VALID_I,
    input  wire logic [31:0]            RX_STAT_I,
    input  wire logic                   RX_STAT_VALID_I,
    // Stream to the RX data FIFO
    output rcoe_byte_t                  FIFO_BYTE_O,
    output logic                        FIFO_VALID_O,
    output logic      [31:0]            FIFO_STAT_O,
    output logic                        FIFO_STAT_VALID_O
);

    rcoe_state_t q;
    rcoe_state_t d;
    logic [15:0] ftype;
    logic        sum_byte;

    // Next-state logic: register port, parser, accumulator, output stream
    always_comb begin
        d         = q;
        ftype     = {q.type_hi, RX_BYTE_I.data};
        sum_byte  = 1'b0;
        d.o_valid = 1'b0;
        d.o_sval  = 1'b0;
        d.o_byte  = '0;
        d.rdata   = 32'h0000_0000;

        // Register writes; enable and mode only reach the datapath at frame start, the tag type at once
        if (REG_WE_I) begin
            if (REG_ADDR_I == RCOE_OFF_CTRL) begin
                d.ctrl_en   = REG_WDATA_I[RCOE_CTRL_EN_BIT];   // [R9]
                d.ctrl_mode = REG_WDATA_I[RCOE_CTRL_MODE_BIT]; // [R9]
            end else if (REG_ADDR_I == RCOE_OFF_VLAN) begin
                d.vlan_type = REG_WDATA_I[15:0];               // [R4]
            end
        end

        // Register reads, answered the next cycle; unmapped reads zero
        if (REG_RE_I) begin
            if (REG_ADDR_I == RCOE_OFF_CTRL) begin
                d.rdata = {30'h0000_0000, q.ctrl_mode, q.ctrl_en};
            end else if (REG_ADDR_I == RCOE_OFF_VLAN) begin
                d.rdata = {16'h0000, q.vlan_type};
            end else if (REG_ADDR_I == RCOE_OFF_STAT) begin
                d.rdata = {24'h00_0000, q.stat_pend, q.vlan_cnt, q.start_ok,
                           q.st != RCOE_IDLE, q.odd, q.mode, q.en};
            end
        end

        // First byte of a frame: latch settings and reset the parser
        if (q.st == RCOE_IDLE && RX_VALID_I) begin
            d.en        = q.ctrl_en;                           // [R17]
            d.mode      = q.ctrl_mode;                         // [R17]
            d.pos       = '0;
            d.type_pos  = RCOE_TYPE_POS;
            d.start_pos = RCOE_HDR_BYTES;                      // [R2]
            d.start_ok  = !q.ctrl_mode;                        // [R2]
            d.vlan_cnt  = 2'h0;
            d.odd       = 1'b0;
            d.sum       = 16'h0000;
            d.st        = RCOE_FRAME;
        end

        case (q.st)
            RCOE_IDLE, RCOE_FRAME: begin
                if (RX_VALID_I) begin
                    // Forward the byte one cycle later
                    d.o_byte      = RX_BYTE_I;                 // [R10]
                    d.o_byte.last = RX_BYTE_I.last && !d.en;   // [R6]
                    d.o_valid     = 1'b1;

                    // Mode 1 header walk up to the layer-3 start
                    if (d.mode && !d.start_ok) begin
                        if (d.pos == d.type_pos) begin
                            d.type_hi = RX_BYTE_I.data;
                        end else if (d.pos == d.type_pos + 12'h001) begin
                            if (ftype == q.vlan_type && d.vlan_cnt < RCOE_MAX_VLAN) begin
                                d.type_pos = d.type_pos + RCOE_VLAN_BYTES; // [R4] [R5]
                                d.vlan_cnt = d.vlan_cnt + 2'h1;            // [R5]
                            end else if (ftype < RCOE_LEN_TYPE_MIN) begin
                                d.start_pos = d.pos + 12'h001 + RCOE_SNAP_BYTES; // [R3]
                                d.start_ok  = 1'b1;
                            end else begin
                                d.start_pos = d.pos + 12'h001; // [R3] [R5]
                                d.start_ok  = 1'b1;
                            end
                        end
                    end

                    // Word accumulation, earlier byte low, later byte high
                    sum_byte = d.en && d.start_ok && (d.pos >= d.start_pos)
                               && !RX_BYTE_I.fcs;              // [R1] [R2] [R8]
                    if (sum_byte) begin
                        if (d.odd) begin
                            d.sum = rcoe_fold(d.sum, {RX_BYTE_I.data, d.low}); // [R14] [R15]
                            d.odd = 1'b0;
                        end else begin
                            d.low = RX_BYTE_I.data;
                            d.odd = 1'b1;                      // [R13]
                        end
                    end

                    // End of frame: close an odd word, then append
                    if (RX_BYTE_I.last) begin
                        if (d.en) begin
                            if (d.odd) begin
                                d.sum = rcoe_fold(d.sum, {8'h00, d.low}); // [R16] [R13]
                            end
                            d.odd = 1'b0;
                            d.st  = RCOE_APP_LO;               // [R8]
                        end else begin
                            d.st  = RCOE_IDLE;                 // [R10]
                        end
                    end

                    // Saturating byte position
                    if (d.pos != '1) begin
                        d.pos = d.pos + 12'h001;
                    end
                end
            end
            RCOE_APP_LO: begin
                // Low checksum byte right after the last frame byte
                d.o_byte.data = q.sum[7:0];                    // [R6]
                d.o_valid     = 1'b1;
                d.st          = RCOE_APP_HI;
            end
            RCOE_APP_HI: begin
                // High checksum byte closes the frame
                d.o_byte.data = q.sum[15:8];                   // [R6]
                d.o_byte.last = 1'b1;
                d.o_valid     = 1'b1;
                d.st          = RCOE_IDLE;
            end
            default: begin
                d.st = RCOE_IDLE;
            end
        endcase

        // Held status leaves once the checksum bytes are out
        if (q.st == RCOE_IDLE && q.stat_pend) begin
            d.o_sval    = 1'b1;                                // [R6]
            d.o_stat    = q.stat;
            d.stat_pend = 1'b0;
        end

        // Status from the MAC: pass through or hold with length plus two
        if (RX_STAT_VALID_I) begin
            if (q.en) begin
                d.stat      = RX_STAT_I;
                d.stat[RCOE_STAT_LEN_LSB +: RCOE_STAT_LEN_W] =
                    RX_STAT_I[RCOE_STAT_LEN_LSB +: RCOE_STAT_LEN_W]
                    + RCOE_CSUM_BYTES;                         // [R7]
                d.stat_pend = 1'b1;
            end else begin
                d.o_sval    = 1'b1;                            // [R10]
                d.o_stat    = RX_STAT_I;
            end
        end
    end

    // State register
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            q           <= '0;
            q.st        <= RCOE_IDLE;
            q.ctrl_en   <= RCOE_EN_RST;                        // [R17]
            q.ctrl_mode <= RCOE_MODE_RST;                      // [R17]
            q.vlan_type <= RCOE_VLAN_RST;                      // [R4]
            q.type_pos  <= RCOE_TYPE_POS;
            q.start_pos <= RCOE_HDR_BYTES;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register
    assign REG_RDATA_O       = q.rdata;
    assign FIFO_BYTE_O       = q.o_byte;
    assign FIFO_VALID_O      = q.o_valid;
    assign FIFO_STAT_O       = q.o_stat;
    assign FIFO_STAT_VALID_O = q.o_sval;

    // Checks
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!NRST_I);

    // Every byte arriving in idle or frame state appears one cycle later with its data unchanged
    property p_forward;
        RX_VALID_I && (q.st == RCOE_IDLE || q.st == RCOE_FRAME)
        |=> FIFO_VALID_O && FIFO_BYTE_O.data == $past(RX_BYTE_I.data);
    endproperty
    a_forward: assert property (p_forward) else $error("byte not forwarded"); // [R1]

    // Disabled frame ends on its own last byte, nothing appended
    property p_bypass_end;
        RX_VALID_I && RX_BYTE_I.last && q.st == RCOE_FRAME && !q.en
        |=> FIFO_BYTE_O.last ##1 !FIFO_VALID_O;
    endproperty
    a_bypass_end: assert property (p_bypass_end) else $error("bypass frame altered"); // [R10]

    // Disabled status passes through unchanged
    property p_bypass_stat;
        RX_STAT_VALID_I && !q.en |=> FIFO_STAT_VALID_O && FIFO_STAT_O == $past(RX_STAT_I);
    endproperty
    a_bypass_stat: assert property (p_bypass_stat) else $error("bypass status altered"); // [R10]

    // Enabled frame: two checksum bytes follow, the second marked last
    property p_append;
        RX_VALID_I && RX_BYTE_I.last && q.st == RCOE_FRAME && q.en
        |=> !FIFO_BYTE_O.last ##1 FIFO_VALID_O && FIFO_BYTE_O.data == q.sum[7:0]
            ##1 FIFO_VALID_O && FIFO_BYTE_O.last;
    endproperty
    a_append: assert property (p_append) else $error("checksum not appended"); // [R6] [R8]

    // Enabled status leaves with length raised by two
    property p_len;
        RX_STAT_VALID_I && q.en && !q.stat_pend
        && (q.st == RCOE_IDLE || q.st == RCOE_APP_HI)
        |=> ##1 FIFO_STAT_VALID_O
            && FIFO_STAT_O[RCOE_STAT_LEN_LSB +: RCOE_STAT_LEN_W]
               == $past(RX_STAT_I[RCOE_STAT_LEN_LSB +: RCOE_STAT_LEN_W], 2)
                  + RCOE_CSUM_BYTES;
    endproperty
    a_len: assert property (p_len) else $error("status length not adjusted"); // [R7]

    // Settings frozen while a frame is in flight
    property p_freeze;
        q.st != RCOE_IDLE |=> $stable(q.en) && $stable(q.mode);
    endproperty
    a_freeze: assert property (p_freeze) else $error("settings changed mid-frame"); // [R17]

    // Mode 0 starts summing after the fixed header
    property p_mode0;
        q.st == RCOE_FRAME && !q.mode |-> q.start_ok && q.start_pos == RCOE_HDR_BYTES;
    endproperty
    a_mode0: assert property (p_mode0) else $error("mode 0 start wrong"); // [R2]

    // Never more than two tags skipped
    property p_vlan_max;
        q.st == RCOE_FRAME |-> q.vlan_cnt <= RCOE_MAX_VLAN;
    endproperty
    a_vlan_max: assert property (p_vlan_max) else $error("too many tags skipped"); // [R5]

    // Mode 1 start lies beyond the final type field
    property p_mode1;
        q.st == RCOE_FRAME && q.mode && q.start_ok
        |-> q.start_pos >= q.type_pos + 12'h002;
    endproperty
    a_mode1: assert property (p_mode1) else $error("mode 1 start inside header"); // [R3]

    // No half word left over when the checksum goes out
    property p_pad;
        q.st == RCOE_APP_LO |-> !q.odd;
    endproperty
    a_pad: assert property (p_pad) else $error("odd byte not padded"); // [R13] [R16]

    // Control write reaches the enable bit
    property p_ctrl;
        REG_WE_I && REG_ADDR_I == RCOE_OFF_CTRL
        |=> q.ctrl_en == $past(REG_WDATA_I[RCOE_CTRL_EN_BIT]);
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("enable bit not written"); // [R9]

    // No read strobe, read data back to zero
    property p_rd_idle;
        !REG_RE_I |=> REG_RDATA_O == 32'h0000_0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero"); // [R9]

    // Control read returns both setting bits
    property p_rd_ctrl;
        REG_RE_I && REG_ADDR_I == RCOE_OFF_CTRL
        |=> REG_RDATA_O == {30'h0000_0000, $past(q.ctrl_mode), $past(q.ctrl_en)};
    endproperty
    a_rd_ctrl: assert property (p_rd_ctrl) else $error("control read wrong"); // [R9]

    // Control write reaches the mode bit
    property p_mode_wr;
        REG_WE_I && REG_ADDR_I == RCOE_OFF_CTRL
        |=> q.ctrl_mode == $past(REG_WDATA_I[RCOE_CTRL_MODE_BIT]);
    endproperty
    a_mode_wr: assert property (p_mode_wr) else $error("mode bit not written"); // [R9]

    // Tag type write reaches the tag register
    property p_vlan_wr;
        REG_WE_I && REG_ADDR_I == RCOE_OFF_VLAN
        |=> q.vlan_type == $past(REG_WDATA_I[15:0]);
    endproperty
    a_vlan_wr: assert property (p_vlan_wr) else $error("tag type not written"); // [R4]

    // First byte of a frame takes the programmed settings
    property p_latch;
        q.st == RCOE_IDLE && RX_VALID_I
        |=> q.en == $past(q.ctrl_en) && q.mode == $past(q.ctrl_mode);
    endproperty
    a_latch: assert property (p_latch) else $error("settings not taken at frame start"); // [R17]

    // FCS bytes ahead of the last one leave the sum alone
    property p_fcs_hold;
        q.st == RCOE_FRAME && RX_VALID_I && RX_BYTE_I.fcs && !RX_BYTE_I.last
        |=> $stable(q.sum);
    endproperty
    a_fcs_hold: assert property (p_fcs_hold) else $error("FCS byte summed"); // [R2]

    // Mode 0 header bytes are never summed
    property p_hdr_hold;
        q.st == RCOE_FRAME && RX_VALID_I && !q.mode && q.pos < RCOE_HDR_BYTES
        |=> $stable(q.sum);
    endproperty
    a_hdr_hold: assert property (p_hdr_hold) else $error("header byte summed"); // [R2]

    // Mode 1 bytes ahead of the layer-3 start are never summed
    property p_walk_hold;
        q.st == RCOE_FRAME && RX_VALID_I && q.mode && (!q.start_ok || q.pos < q.start_pos)
        |=> $stable(q.sum);
    endproperty
    a_walk_hold: assert property (p_walk_hold) else $error("mode 1 header byte summed"); // [R3]

    // Disabled frames leave the sum cleared
    property p_off_zero;
        q.st == RCOE_FRAME && !q.en |-> q.sum == 16'h0000;
    endproperty
    a_off_zero: assert property (p_off_zero) else $error("sum built while disabled"); // [R10]

endmodule : rcoe_engine

// [tb/rcoe_mac_model.sv]
// Behavioural MAC receive path that feeds frames and status to the engine
module rcoe_mac_model
    import rcoe_pkg::*;
(
    // Clock
    input  wire logic   clk_i,
    // Receive stream towards the engine
    output rcoe_byte_t  rx_byte_o,
    output logic        rx_valid_o,
    output logic [31:0] rx_stat_o,
    output logic        rx_stat_valid_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Quiet lines from time zero
    initial begin
        rx_byte_o       = '0;
        rx_valid_o      = 1'b0;
        rx_stat_o       = '0;
        rx_stat_valid_o = 1'b0;
    end

    // One whole frame, FCS included, then its status word
    task automatic send_frame(input rcoe_byte_t fr[$], input logic [31:0] stat, input int gap);
        int i;
        for (i = 0; i < fr.size(); i++) begin
            @(posedge clk_i);
            rx_byte_o  <= fr[i]; // Frames kept whole, pads never stripped
            rx_valid_o <= 1'b1;
            if (gap != 0 && i[0]) begin
                @(posedge clk_i);
                rx_valid_o <= 1'b0;
                rx_byte_o  <= ~fr[i]; // Idle lines show no stale byte
            end
        end
        @(posedge clk_i);
        rx_valid_o      <= 1'b0;
        rx_byte_o       <= ~fr[fr.size()-1];
        rx_stat_o       <= stat; // Status one cycle after the last byte, two if a gap cycle follows it
        rx_stat_valid_o <= 1'b1;
        @(posedge clk_i);
        rx_stat_valid_o <= 1'b0;
        rx_stat_o       <= ~stat;
    endtask : send_frame
endmodule : rcoe_mac_model

// [tb/tb.sv]
// Self-checking bench for the receive checksum engine
module tb
    import rcoe_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic                   clk;
    logic                   rst_n;
    logic [RCOE_ADDR_W-1:0] reg_addr;
    logic [31:0]            reg_wdata;
    logic                   reg_we;
    logic                   reg_re;
    logic [31:0]            reg_rdata;
    rcoe_byte_t             rx_byte;
    logic                   rx_valid;
    logic [31:0]            rx_stat;
    logic                   rx_stat_valid;
    rcoe_byte_t             fifo_byte;
    logic                   fifo_valid;
    logic [31:0]            fifo_stat;
    logic                   fifo_stat_valid;
    rcoe_byte_t             fr[$];
    rcoe_byte_t             got[$];
    logic [31:0]            stat_seen;
    logic [31:0]            rd;
    int                     stat_cnt;
    int                     err_total;
    int                     checks;

    rcoe_engine rcoe_engine_inst (
        .CLK_I(clk), .NRST_I(rst_n), .REG_ADDR_I(reg_addr), .REG_WDATA_I(reg_wdata),
        .REG_WE_I(reg_we), .REG_RE_I(reg_re), .REG_RDATA_O(reg_rdata),
        .RX_BYTE_I(rx_byte), .RX_VALID_I(rx_valid), .RX_STAT_I(rx_stat),
        .RX_STAT_VALID_I(rx_stat_valid), .FIFO_BYTE_O(fifo_byte), .FIFO_VALID_O(fifo_valid),
        .FIFO_STAT_O(fifo_stat), .FIFO_STAT_VALID_O(fifo_stat_valid)
    );

    rcoe_mac_model rcoe_mac_model_inst (
        .clk_i(clk), .rx_byte_o(rx_byte), .rx_valid_o(rx_valid),
        .rx_stat_o(rx_stat), .rx_stat_valid_o(rx_stat_valid)
    );

    // Clock at 200 MHz
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Collects everything the engine hands to the FIFO
    always @(posedge clk) begin
        if (fifo_valid === 1'b1) got.push_back(fifo_byte);
        if (fifo_stat_valid === 1'b1) begin
            stat_seen = fifo_stat;
            stat_cnt++;
        end
    end

    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict

    task automatic cmp_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp_word

    task automatic cmp_byte(input string nm, input rcoe_byte_t e, input rcoe_byte_t g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp_byte

    // Register port cycles, one strobe cycle each
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_we    <= 1'b1;
        @(posedge clk);
        reg_we    <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_re   <= 1'b1;
        @(posedge clk);
        reg_re   <= 1'b0;
        #1 d = reg_rdata;
    endtask : reg_rd

    // Header of 12 address bytes, given type words, payload, then 4 FCS bytes
    task automatic mk(input logic [15:0] tw[$], input int np);
        int i;
        fr.delete();
        for (i = 0; i < 12; i++) fr.push_back('{8'h10 + 8'(i), 1'b0, 1'b0});
        foreach (tw[k]) begin
            fr.push_back('{tw[k][15:8], 1'b0, 1'b0});
            fr.push_back('{tw[k][7:0], 1'b0, 1'b0});
        end
        for (i = 0; i < np; i++) fr.push_back('{8'hff - 8'(i * 7), 1'b0, 1'b0});
        for (i = 0; i < 4; i++) fr.push_back('{8'hc0 + 8'(i), 1'b1, i == 3});
    endtask : mk

    // Word sum from a start byte, later byte high, carry folded back
    function automatic logic [15:0] csum(input int st);
        logic [16:0] a;
        logic [15:0] w;
        a = '0;
        for (int i = st; i < fr.size(); i += 2) begin
            if (!fr[i].fcs) begin
                w = (!fr[i+1].fcs) ? {fr[i+1].data, fr[i].data} : {8'h00, fr[i].data};
                a = {1'b0, a[15:0]} + {1'b0, w};
                a = {1'b0, a[15:0]} + {16'h0000, a[16]};
            end
        end
        return a[15:0];
    endfunction : csum

    task automatic run(input logic en, input logic md, input int st, input int gap,
                       input string nm);
        rcoe_byte_t  e;
        logic [15:0] cs;
        logic [31:0] si;
        int          n;
        int          t;
        n  = fr.size();
        si = {2'b00, 14'(n), 16'h5a3c};
        reg_wr(RCOE_OFF_CTRL, {30'h0, md, en}); // Written only while idle
        got.delete();
        stat_cnt = 0;
        rcoe_mac_model_inst.send_frame(fr, si, gap);
        for (t = 0; t < 200 && stat_cnt == 0; t++) @(posedge clk);
        if (stat_cnt == 0) begin
            err_total++;
            $display("BAD status wait");
            print_verdict();
        end
        repeat (4) @(posedge clk);
        cs = csum(st);
        cmp_word("byte count", 32'(n + (en ? 2 : 0)), 32'(got.size()));
        for (int i = 0; i < n && i < got.size(); i++) begin
            e = fr[i];
            if (en) e.last = 1'b0;
            cmp_byte("frame byte", e, got[i]);
        end
        if (en && got.size() == n + 2) begin
            cmp_byte("csum low", '{cs[7:0], 1'b0, 1'b0}, got[n]);
            cmp_byte("csum high", '{cs[15:8], 1'b0, 1'b1}, got[n+1]);
        end
        cmp_word("status", en ? si + 32'h0002_0000 : si, stat_seen);
        cmp_word("status count", 32'h1, 32'(stat_cnt));
        $display("Test %s done", nm);
    endtask : run

    // Main sequence
    initial begin
        err_total = 0;
        checks    = 0;
        stat_cnt  = 0;
        rst_n     = 1'b0;
        reg_addr  = '0;
        reg_wdata = '0;
        reg_we    = 1'b0;
        reg_re    = 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        reg_rd(RCOE_OFF_CTRL, rd);
        cmp_word("ctrl reset", 32'h0, rd);
        reg_rd(RCOE_OFF_VLAN, rd);
        cmp_word("tag type reset", 32'h0000_8100, rd);
        reg_rd(4'hc, rd);
        cmp_word("unmapped", 32'h0, rd);
        $display("Test reset done");
        mk('{16'h0800}, 9);
        run(1'b0, 1'b0, 14, 0, "pass");
        run(1'b1, 1'b0, 14, 1, "mode0_odd");
        reg_rd(RCOE_OFF_CTRL, rd);
        cmp_word("ctrl", 32'h1, rd);
        mk('{16'h0800}, 10);
        run(1'b1, 1'b0, 14, 0, "mode0_even");
        mk('{16'h86dd}, 7);
        run(1'b1, 1'b1, 14, 1, "mode1_type");
        mk('{16'h8100, 16'h0005, 16'h0800}, 8);
        run(1'b1, 1'b1, 18, 0, "mode1_tag");
        mk('{16'h8100, 16'h0001, 16'h8100, 16'h0002, 16'h8100, 16'h0003, 16'h0800}, 6);
        run(1'b1, 1'b1, 22, 0, "mode1_three_tags");
        reg_rd(RCOE_OFF_STAT, rd);
        cmp_word("status reg", 32'h0000_0053, rd);
        mk('{16'h002e, 16'haaaa, 16'h0300, 16'h0000, 16'h0800}, 8);
        run(1'b1, 1'b1, 22, 1, "mode1_snap");
        mk('{16'h8100, 16'h0007, 16'h0030, 16'haaaa, 16'h0300, 16'h0000, 16'h0800}, 5);
        run(1'b1, 1'b1, 26, 0, "mode1_tag_snap");
        reg_wr(RCOE_OFF_VLAN, 32'h0000_88a8);
        mk('{16'h88a8, 16'h0009, 16'h0800}, 5);
        run(1'b1, 1'b1, 18, 0, "new_tag_type");
        mk('{16'h8100, 16'h0009, 16'h0800}, 5);
        run(1'b1, 1'b1, 14, 0, "old_tag_type");
        run(1'b0, 1'b1, 14, 0, "disabled_again");
        print_verdict();
    end
endmodule : tb
